// file: logic/mcs_serial_select.sv
// Serial interface between the MAC receive path and the Manchester codec, internal or external.
// Assumes recvClk is the codec recovered clock; the strap is static after reset.
`timescale 1ns/10ps
// Notes on behaviour
// - Strap high selects external codec inputs.
// - Internal carrier sense to MAC and pin.
// - Carrier asserts on first high-to-low transition.
// - Carrier held 1.5 bit times after data.
// - Internal collision active high, to MAC and pin.
// - Collision watched from SFD to packet end.
// - Collision watched after transmit for heartbeat.
// - Internal NRZ data to MAC and pin.
// - External data captured on rising clock.
// - Data pin floats until config written.
// - Extended bus option makes pin user output.
// - User output floats until first bus mastership.
module mcs_serial_select #(
  parameter int HOLD_CYCLES = mcs_pkg::CRS_HOLD_CYCLES
) (
  input  wire logic ref_clk,
  input  wire logic reset,
  input  wire logic recvClk,
  input  wire logic extCodecSelect,
  input  wire logic lineRxData,
  input  wire logic lineRxActive,
  input  wire logic lineCollision,
  input  wire logic codecNrzData,
  input  wire logic carrierSenseIn,
  input  wire logic collisionIn,
  input  wire logic recvNrzIn,
  input  wire logic dataConfigWrite,
  input  wire logic extendedBusOption,
  input  wire logic userOutZeroLevel,
  input  wire logic busMasterGrant,
  input  wire logic txActive,
  input  wire logic txSfdStart,
  input  wire logic macReady,
  output logic      carrierSenseOut,
  output logic      collisionOut,
  output logic      recvNrzOut,
  output logic      recvNrzOutEn_n,
  output logic      recvClockOut,
  output logic      macValid,
  output logic      macData,
  output logic      macCarrier,
  output logic      macCollision,
  output logic      macHeartbeat,
  output logic      bufferFull
);
  import mcs_pkg::*;

  // Link domain: carrier detect and data capture on the recovered clock.
  logic             lineRxPrev_reg;
  logic             intCrs_reg;
  logic [CNT_W-1:0] holdCnt_reg;
  logic             capData_reg;
  logic             capTog_reg;
  logic             selSyncL1_reg;
  logic             selSyncL2_reg;
  logic             resetL1_reg;
  logic             resetL2_reg;
  wire  logic       fallEdge = lineRxPrev_reg & ~lineRxData & lineRxActive;
  wire  logic       linkCarrier = selSyncL2_reg ? carrierSenseIn : intCrs_reg;
  wire  logic       linkData = selSyncL2_reg ? recvNrzIn : codecNrzData;
  wire  logic [CNT_W-1:0] holdLoad = HOLD_CYCLES[CNT_W-1:0];

  always_ff @(posedge recvClk) begin
    resetL1_reg   <= reset;
    resetL2_reg   <= resetL1_reg;
    selSyncL1_reg <= extCodecSelect;
    selSyncL2_reg <= selSyncL1_reg;
  end

  always_ff @(posedge recvClk) begin
    if (resetL2_reg) begin
      // Idle line level is high, so the first falling edge of a frame is still seen.
      lineRxPrev_reg <= 1'b1;
      intCrs_reg     <= 1'b0;
      holdCnt_reg    <= CNT_ZERO;
    end else begin
      lineRxPrev_reg <= lineRxData;
      if (!intCrs_reg && fallEdge) begin
        intCrs_reg  <= 1'b1;
        holdCnt_reg <= holdLoad;
      end else if (lineRxActive) begin
        holdCnt_reg <= holdLoad;
      end else if (holdCnt_reg != CNT_ZERO) begin
        holdCnt_reg <= holdCnt_reg - 8'h01;
      end else begin
        intCrs_reg <= 1'b0;
      end
    end
  end

  // Data is captured on each rising recovered clock edge while carrier is up.
  always_ff @(posedge recvClk) begin
    if (resetL2_reg) begin
      capData_reg <= 1'b0;
      capTog_reg  <= 1'b0;
    end else if (linkCarrier) begin
      capData_reg <= linkData;
      capTog_reg  <= ~capTog_reg;
    end
  end

  // System domain: synchronisers.
  logic       togS1_reg, togS2_reg, togS3_reg;
  logic       crsS1_reg, crsS2_reg;
  logic       colS1_reg, colS2_reg;
  logic       selS1_reg, selS2_reg;
  logic       lcolS1_reg, lcolS2_reg;
  logic       capDataHold_reg;
  logic       dataS_reg;

  always_ff @(posedge ref_clk) begin
    togS1_reg  <= capTog_reg;
    togS2_reg  <= togS1_reg;
    togS3_reg  <= togS2_reg;
    crsS1_reg  <= linkCarrier;
    crsS2_reg  <= crsS1_reg;
    colS1_reg  <= collisionIn;
    colS2_reg  <= colS1_reg;
    lcolS1_reg <= lineCollision;
    lcolS2_reg <= lcolS1_reg;
    selS1_reg  <= extCodecSelect;
    selS2_reg  <= selS1_reg;
    capDataHold_reg <= capData_reg;
    dataS_reg  <= capDataHold_reg;
  end

  wire logic newWord = togS2_reg ^ togS3_reg;

  // Collision detect from the 10 MHz signal: any activity held briefly.
  logic [3:0] colPulse_reg;
  always_ff @(posedge ref_clk) begin
    if (reset) colPulse_reg <= 4'h0;
    else if (lcolS2_reg) colPulse_reg <= COL_PULSE_MAX;
    else if (colPulse_reg != 4'h0) colPulse_reg <= colPulse_reg - 4'h1;
  end
  wire logic intCollision = colPulse_reg != 4'h0;
  wire logic selCollision = selS2_reg ? colS2_reg : intCollision;

  // Collision watch: during transmit from SFD, then for heartbeat after.
  mcs_col_state_t colState_reg, colState_next;
  always_comb begin
    colState_next = colState_reg;
    case (colState_reg)
      MCS_IDLE:  if (txSfdStart) colState_next = MCS_XMIT;
      MCS_XMIT:  if (!txActive) colState_next = MCS_HBEAT;
      MCS_HBEAT: if (txSfdStart) colState_next = MCS_XMIT;
                 else if (selCollision) colState_next = MCS_IDLE;
      default:   colState_next = MCS_IDLE;
    endcase
  end

  logic configWritten_reg, masterSeen_reg;
  logic [BUF_DEPTH-1:0] bufData_reg, bufValid_reg;

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      colState_reg      <= MCS_IDLE;
      macCollision      <= 1'b0;
      macHeartbeat      <= 1'b0;
      carrierSenseOut   <= 1'b0;
      collisionOut      <= 1'b0;
      macCarrier        <= 1'b0;
      configWritten_reg <= 1'b0;
      masterSeen_reg    <= 1'b0;
      recvNrzOut        <= 1'b0;
    end else begin
      colState_reg    <= colState_next;
      macCollision    <= (colState_reg == MCS_XMIT) & selCollision;
      macHeartbeat    <= (colState_reg == MCS_HBEAT) & selCollision;
      carrierSenseOut <= ~selS2_reg & crsS2_reg;
      collisionOut    <= ~selS2_reg & intCollision;
      macCarrier      <= crsS2_reg;
      if (dataConfigWrite) configWritten_reg <= 1'b1;
      if (busMasterGrant) masterSeen_reg <= 1'b1;
      recvNrzOut <= extendedBusOption ? userOutZeroLevel : dataS_reg;
    end
  end

  // Pin driven only when internal codec or user mode allows it.
  wire logic pinDrive = configWritten_reg &
                        (extendedBusOption ? masterSeen_reg
                                           : ~selS2_reg);
  assign recvNrzOutEn_n = ~pinDrive;
  assign recvClockOut   = ~selS2_reg & recvClk;

  // Two-entry buffer toward the MAC; a word is pushed per captured bit while the buffer is not full.
  wire logic pushOk = newWord & ~bufValid_reg[1];
  wire logic popOk  = bufValid_reg[0] & macReady;
  always_ff @(posedge ref_clk) begin
    if (reset) begin
      bufValid_reg <= '0;
      bufData_reg  <= '0;
    end else begin
      case ({pushOk, popOk})
        2'b10: begin
          bufValid_reg <= {bufValid_reg[0], 1'b1};
          if (bufValid_reg[0]) bufData_reg[1] <= dataS_reg;
          else bufData_reg[0] <= dataS_reg;
        end
        2'b01: begin
          bufValid_reg <= {1'b0, bufValid_reg[1]};
          bufData_reg  <= {1'b0, bufData_reg[1]};
        end
        2'b11: begin
          if (bufValid_reg[1]) bufData_reg <= {dataS_reg, bufData_reg[1]};
          else bufData_reg[0] <= dataS_reg;
        end
        default: bufValid_reg <= bufValid_reg;
      endcase
    end
  end
  assign macValid   = bufValid_reg[0];
  assign macData    = bufData_reg[0];
  assign bufferFull = bufValid_reg[1];
endmodule // mcs_serial_select

// file: logic/mcs_pkg.sv
// Constants for the MAC to codec serial selector.
// Assumes a 25 MHz system clock and a codec line rate of 10 Mbit/s.
package mcs_pkg;
  localparam int BIT_TIME_NS = 100;
  localparam int CRS_HOLD_HALF_BITS = 3;
  localparam int LINK_CLK_NS = 12;
  localparam int CRS_HOLD_CYCLES = (BIT_TIME_NS * CRS_HOLD_HALF_BITS / 2 + LINK_CLK_NS - 1)
                                   / LINK_CLK_NS;
  localparam int CNT_W = 8;
  localparam logic [CNT_W-1:0] CRS_HOLD_COUNT = CRS_HOLD_CYCLES[CNT_W-1:0];
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
  localparam int BUF_DEPTH = 2;
  localparam logic [3:0] COL_PULSE_MAX = 4'h4;
  typedef enum logic [1:0] {
    MCS_IDLE  = 2'b00,
    MCS_XMIT  = 2'b01,
    MCS_HBEAT = 2'b11
  } mcs_col_state_t;
endpackage

// file: dv/mcs_serial_select_monitor.sv
// Concurrent checks on the serial selector ports.
// Assumes a bind into mcs_serial_select.
`timescale 1ns/10ps
module mcs_serial_select_monitor (
  input wire logic ref_clk, reset, extCodecSelect, lineCollision, collisionIn, txActive,
  input wire logic dataConfigWrite, extendedBusOption, userOutZeroLevel, busMasterGrant,
  input wire logic macReady, macValid, macData, carrierSenseOut, collisionOut,
  input wire logic recvNrzOut, recvNrzOutEn_n, recvClockOut, macCollision, bufferFull
);
  logic cfgSeen_reg, mstSeen_reg;
  always_ff @(posedge ref_clk) begin
    cfgSeen_reg <= !reset && (cfgSeen_reg || dataConfigWrite);
    mstSeen_reg <= !reset && (mstSeen_reg || busMasterGrant);
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  a_ext_quiet: assert property (extCodecSelect [*4] |->
    !(carrierSenseOut || collisionOut || recvClockOut)) else $error("internal outputs leak");
  a_cfg_float: assert property (!cfgSeen_reg |-> recvNrzOutEn_n)
    else $error("pin driven before config");
  a_user_float: assert property (extendedBusOption && $past(extendedBusOption)
    && !mstSeen_reg |-> recvNrzOutEn_n) else $error("user pin driven early");
  a_user_level: assert property ((extendedBusOption && userOutZeroLevel
    && mstSeen_reg && cfgSeen_reg) [*3] |-> !recvNrzOutEn_n && recvNrzOut)
    else $error("user pin level wrong");
  a_col_pin: assert property (!extCodecSelect && lineCollision |-> ##[1:6] collisionOut)
    else $error("collision pin missing");
  a_ext_col: assert property (extCodecSelect && txActive && collisionIn
    |-> ##[1:6] macCollision) else $error("external collision missing");
  a_valid_hold: assert property (macValid && !macReady |=> macValid && $stable(macData))
    else $error("head bit dropped");
  a_full_head: assert property (bufferFull |-> macValid)
    else $error("full without head");
endmodule // mcs_serial_select_monitor

// file: dv/mcs_codec_model.sv
// Codec stand-in: gated recovered clock, one byte per frame on both codec faces.
// Assumes linkClk runs free; the clock spins in reset so the link side resets.
`timescale 1ns/10ps
module mcs_codec_model (
  input  wire logic       linkClk, reset, frameStart, colReq,
  input  wire logic [7:0] frameByte,
  output logic            recvClk, lineRxData, lineRxActive, codecNrzData,
  output logic            carrierSenseIn, recvNrzIn, collisionIn
);
  logic [9:0] cnt_reg = 10'h000;
  logic [7:0] byte_reg = 8'h00;
  logic       tog_reg = 1'b0;
  wire        dataOn = cnt_reg[9] && cnt_reg[8:7] == 2'b00;
  wire        bitNow = byte_reg[~cnt_reg[6:4]];
  initial recvClk = 1'b0;
  // Clock keeps pulsing after the data so the carrier hold can run out.
  always @(posedge linkClk) begin
    cnt_reg <= frameStart ? 10'h200 : cnt_reg[9] ? cnt_reg + 10'h001 : cnt_reg;
    byte_reg <= frameStart ? frameByte : byte_reg;
    tog_reg <= ~tog_reg;
    recvClk <= reset ? ~recvClk : cnt_reg[9] && cnt_reg[3:2] == 2'b10;
  end
  assign carrierSenseIn = dataOn;
  assign codecNrzData = dataOn ? bitNow : tog_reg;
  assign recvNrzIn = codecNrzData;
  assign lineRxActive = dataOn;
  assign lineRxData = dataOn ? bitNow ^ cnt_reg[3] : 1'b1;
  assign collisionIn = colReq;
endmodule // mcs_codec_model

// file: dv/tb_mcs_serial_select.sv
// Self-checking bench for the serial selector and a codec stand-in.
// Assumes the strap changes only while reset is held.
`timescale 1ns/10ps
module tb_mcs_serial_select;
  logic ref_clk = 1'b0, linkClk = 1'b0, reset = 1'b1, extCodecSelect = 1'b0, macReady = 1'b0;
  logic lineCollision = 1'b0, dataConfigWrite = 1'b0, extendedBusOption = 1'b0, colReq = 1'b0;
  logic userOutZeroLevel = 1'b0, busMasterGrant = 1'b0, txActive = 1'b0, txSfdStart = 1'b0;
  logic frameStart = 1'b0, recvClk, lineRxData, lineRxActive, codecNrzData, carrierSenseIn;
  logic recvNrzIn, collisionIn, carrierSenseOut, collisionOut, recvNrzOut, recvNrzOutEn_n;
  logic recvClockOut, macValid, macData, macCarrier, macCollision, macHeartbeat, bufferFull;
  logic [7:0] frameByte = 8'h00, got;
  int errors = 0, tests_run = 0, cycles = 0;
  mcs_serial_select DUT (.*);
  mcs_codec_model codec (.*);
  initial forever #20 ref_clk = ~ref_clk;
  initial begin #3; forever #6 linkClk = ~linkClk; end
  always @(posedge ref_clk) if (++cycles == 20000) begin errors++; summarize(); end
  task automatic summarize;
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task automatic check(input string what, input logic seen, input logic exp);
    tests_run++;
    if (seen !== exp) begin errors++; $display("ERROR %s expected %b seen %b", what, exp, seen); end
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic grab(input int n);
    got = 8'h00;
    for (int i = 0; i < 400 && n > 0; i++) begin
      @(posedge ref_clk);
      if (macValid === 1'b1 && macReady === 1'b1) begin got = {got[6:0], macData}; n--; end
    end
  endtask
  task automatic send(input logic [7:0] b);
    frameByte <= b;
    frameStart <= 1'b1;
    wt(1);
    frameStart <= 1'b0;
  endtask
  task automatic t_internal;
    check("pin idle", recvNrzOutEn_n, 1'b1);
    dataConfigWrite <= 1'b1;
    wt(1);
    dataConfigWrite <= 1'b0;
    macReady <= 1'b1;
    wt(4);
    check("pin driven", recvNrzOutEn_n, 1'b0);
    send(8'hFF);
    grab(4);
    check("internal bits", got === 8'h0F, 1'b1);
    check("carrier", carrierSenseOut && macCarrier, 1'b1);
    lineCollision <= 1'b1;
    wt(200);
    check("carrier end", carrierSenseOut, 1'b0);
    check("collision", collisionOut, 1'b1);
    lineCollision <= 1'b0;
  endtask
  task automatic t_external;
    logic hb;
    macReady <= 1'b0;
    send(8'hA5);
    wt(100);
    check("buffer full", bufferFull, 1'b1);
    macReady <= 1'b1;
    grab(2);
    check("stalled bits", got === 8'h02, 1'b1);
    wt(100);
    send(8'h5A);
    grab(8);
    check("external bits", got === 8'h5A, 1'b1);
    txActive <= 1'b1;
    txSfdStart <= 1'b1;
    wt(1);
    {txSfdStart, colReq} <= 2'b01;
    wt(6);
    check("tx collision", macCollision, 1'b1);
    colReq <= 1'b0;
    wt(4);
    txActive <= 1'b0;
    wt(6);
    colReq <= 1'b1;
    hb = 1'b0;
    repeat (6) begin
      @(posedge ref_clk);
      hb = hb | macHeartbeat;
    end
    check("heartbeat", hb, 1'b1);
    {colReq, extendedBusOption, userOutZeroLevel, dataConfigWrite} <= 4'h7;
    wt(1);
    dataConfigWrite <= 1'b0;
    wt(4);
    check("user float", recvNrzOutEn_n, 1'b1);
    busMasterGrant <= 1'b1;
    wt(1);
    busMasterGrant <= 1'b0;
    wt(4);
    check("user drive", !recvNrzOutEn_n && recvNrzOut, 1'b1);
  endtask
  initial begin
    wt(16);
    reset <= 1'b0;
    wt(2);
    t_internal();
    {reset, extCodecSelect} <= 2'b11;
    wt(16);
    reset <= 1'b0;
    wt(2);
    t_external();
    summarize();
  end
endmodule // tb_mcs_serial_select
bind mcs_serial_select mcs_serial_select_monitor mon (.*);
